// [hw/hspo_top.sv]
// Operation
// - Mode pin picks separate or common strobes.
// - Unconnected mode pin means separate strobes.
// - Separate mode: write on strobe rise, select low.
// - Common mode: data strobe rise writes if low.
// - Common mode: read drives bus while select high.
// - Separate mode: read strobe low drives bus.
// - Common mode: read input is read/write select.
// - Format pin picks offset binary or two's complement.
// - Tester pin: code enables eight ten-bit groups.
// - Normal: code enables twenty-bit cascade buses.
// - Accesses honoured only while chip select low.
`timescale 1ns/10ps
module hspo_top (
	input wire logic clk, // 10 MHz system clock.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic strobe_scheme_select, // Strobe scheme, low separate.
	input wire logic chip_sel_n, // Chip select, active low.
	input wire logic read_n, // Read strobe or read/write select.
	input wire logic write_n, // Write strobe or data strobe.
	input wire logic [6:0] addr, // Location address.
	input wire logic [15:0] data_in, // Data bus input side.
	output logic [15:0] data_out, // Data bus output side.
	output logic data_oe, // Data bus drive enable.
	input wire logic output_format_select, // High selects offset binary.
	input wire logic tester_group_tristate, // High selects tester grouping.
	input wire logic [1:0] output_drive_enable_code, // Output enable code.
	input wire logic [79:0] sample_in, // Four 20-bit samples, two's complement.
	output logic [79:0] sample_out, // Formatted output samples.
	output logic [79:0] sample_oe // Per-bit output drive enable.
);
	logic mode_s;
	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic [6:0] addr_s;
	logic [15:0] data_s;
	logic fmt_s;
	logic tri_s;
	logic [1:0] oen_s;
	logic wr_n_d_reg;
	logic [3:0] bus_en;
	logic [7:0] grp_en;
	logic [79:0] oe_next;
	logic [79:0] fmt_next;
	logic [15:0] mem_reg [hspo_pkg::LOC_N];
	hspo_acc_if acc ();

	// All pins but clk, reset_n and sample_in are asynchronous to clk and pass two flip-flops first.
	// Strobes and select reset high, so no access or strobe edge is decoded after reset.
	hspo_sync2 #(.W(4), .INIT(4'h7)) u_sync_ctl (
		.clk(clk),
		.reset_n(reset_n),
		.d({strobe_scheme_select, chip_sel_n, read_n, write_n}),
		.q({mode_s, cs_n_s, rd_n_s, wr_n_s})
	);
	hspo_sync2 #(.W(23)) u_sync_bus (
		.clk(clk),
		.reset_n(reset_n),
		.d({addr, data_in}),
		.q({addr_s, data_s})
	);
	hspo_sync2 #(.W(4)) u_sync_out (
		.clk(clk),
		.reset_n(reset_n),
		.d({output_format_select, tester_group_tristate, output_drive_enable_code}),
		.q({fmt_s, tri_s, oen_s})
	);

	// Delayed write/data strobe for rising edge detection.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_n_d_reg <= 1'b1;
		end else begin
			wr_n_d_reg <= wr_n_s;
		end
	end

	// Strobe decoding for both schemes.
	always_comb begin
		acc.addr = addr_s;
		acc.wdata = data_s;
		acc.wr_pulse = 1'b0;
		acc.rd_active = 1'b0;
		if (!cs_n_s) begin
			if (mode_s == hspo_pkg::STROBE_SEPARATE) begin
				acc.wr_pulse = wr_n_s && !wr_n_d_reg;
				acc.rd_active = !rd_n_s;
			end else begin
				acc.wr_pulse = wr_n_s && !wr_n_d_reg && !rd_n_s;
				acc.rd_active = rd_n_s;
			end
		end
	end

	// Register locations captured on a decoded write.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < hspo_pkg::LOC_N; i++) begin
				mem_reg[i] <= hspo_pkg::LOC_RESET;
			end
		end else if (acc.wr_pulse) begin
			mem_reg[acc.addr] <= acc.wdata;
		end
	end

	// Read data and drive enable, released when no read is active.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			data_out <= hspo_pkg::LOC_RESET;
			data_oe <= 1'b0;
		end else begin
			data_out <= mem_reg[acc.addr];
			data_oe <= acc.rd_active;
		end
	end

	// Enable code decode for both grouping schemes.
	always_comb begin
		bus_en = hspo_pkg::NORM_EN_00;
		grp_en = hspo_pkg::TEST_EN_00;
		unique case (oen_s)
			2'h0: begin
				bus_en = hspo_pkg::NORM_EN_00;
				grp_en = hspo_pkg::TEST_EN_00;
			end
			2'h1: begin
				bus_en = hspo_pkg::NORM_EN_01;
				grp_en = hspo_pkg::TEST_EN_01;
			end
			2'h2: begin
				bus_en = hspo_pkg::NORM_EN_10;
				grp_en = hspo_pkg::TEST_EN_10;
			end
			2'h3: begin
				bus_en = hspo_pkg::NORM_EN_11;
				grp_en = hspo_pkg::TEST_EN_11;
			end
		endcase
	end

	// Expand enables to bits and apply the output format per sample.
	always_comb begin
		oe_next = '0;
		fmt_next = sample_in;
		for (int b = 0; b < hspo_pkg::BUS_N; b++) begin
			if (!tri_s) begin
				oe_next[b*hspo_pkg::BUS_W +: hspo_pkg::BUS_W] = {hspo_pkg::BUS_W{bus_en[b]}};
			end
			fmt_next[b*hspo_pkg::BUS_W + hspo_pkg::SIGN_BIT] =
				sample_in[b*hspo_pkg::BUS_W + hspo_pkg::SIGN_BIT] ^ fmt_s;
		end
		if (tri_s) begin
			for (int g = 0; g < hspo_pkg::GRP_N; g++) begin
				oe_next[g*hspo_pkg::GRP_W +: hspo_pkg::GRP_W] = {hspo_pkg::GRP_W{grp_en[g]}};
			end
		end
	end

	// Registered sample outputs and drive enables.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sample_out <= '0;
			sample_oe <= '0;
		end else begin
			sample_out <= fmt_next;
			sample_oe <= oe_next;
		end
	end
endmodule : hspo_top

// [hw/hspo_pkg.sv]
package hspo_pkg;
	// Bus and address widths of the processor port.
	localparam int DATA_W = 16;
	localparam int ADDR_W = 7;
	localparam int LOC_N = 128;
	// Output bus geometry: four 20-bit buses, eight 10-bit tester groups.
	localparam int BUS_W = 20;
	localparam int BUS_N = 4;
	localparam int OUT_W = 80;
	localparam int GRP_W = 10;
	localparam int GRP_N = 8;
	// Strobe scheme codes; low is the default because the pin is pulled low.
	localparam logic STROBE_SEPARATE = 1'b0;
	localparam logic STROBE_COMMON = 1'b1;
	// Reset value of every register location.
	localparam logic [15:0] LOC_RESET = 16'h0000;
	// Sign bit position of a 20-bit sample, flipped for offset binary.
	localparam int SIGN_BIT = 19;
	// Normal mode enable codes, one bit per 20-bit bus (I in, Q in, I out, Q out).
	localparam logic [3:0] NORM_EN_00 = 4'h0;
	localparam logic [3:0] NORM_EN_01 = 4'h3;
	localparam logic [3:0] NORM_EN_10 = 4'hc;
	localparam logic [3:0] NORM_EN_11 = 4'hf;
	// Tester mode enable codes, one bit per 10-bit group.
	localparam logic [7:0] TEST_EN_00 = 8'h00;
	localparam logic [7:0] TEST_EN_01 = 8'h0f;
	localparam logic [7:0] TEST_EN_10 = 8'hf0;
	localparam logic [7:0] TEST_EN_11 = 8'hff;
endpackage : hspo_pkg

// [hw/hspo_acc_if.sv]
`timescale 1ns/10ps
interface hspo_acc_if;
	logic wr_pulse;
	logic rd_active;
	logic [6:0] addr;
	logic [15:0] wdata;
	modport decoder (output wr_pulse, output rd_active, output addr, output wdata);
	modport store (input wr_pulse, input rd_active, input addr, input wdata);
endinterface : hspo_acc_if

// [hw/hspo_sync2.sv]
`timescale 1ns/10ps
module hspo_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0 // Reset level, matching the idle level of the pins.
) (
	input wire logic clk, // System clock.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic [W-1:0] d, // Asynchronous input.
	output logic [W-1:0] q // Synchronised output.
);
	logic [W-1:0] meta_reg;

	// Two flip-flops; only the second stage is read outside.
	// Both stages reset to the idle level, so no false edge follows reset.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : hspo_sync2

// [tb/hspo_top_asserts.sv]
`timescale 1ns/10ps
module hspo_top_asserts (
	input wire logic clk, // Clock.
	input wire logic reset_n, // Reset.
	input wire logic strobe_scheme_select, // Scheme.
	input wire logic chip_sel_n, // Select.
	input wire logic read_n, // Read.
	input wire logic output_format_select, // Format.
	input wire logic tester_group_tristate, // Tester.
	input wire logic [1:0] output_drive_enable_code, // Code.
	input wire logic [79:0] sample_in, // Samples.
	input wire logic [79:0] sample_out, // Out.
	input wire logic [79:0] sample_oe, // Enables.
	input wire logic data_oe // Bus drive.
);
	logic [2:0] age_reg;
	// Counts edges since reset so that no history reaches back before it.
	always_ff @(posedge clk) begin
		if (!reset_n)
			age_reg <= 3'h0;
		else if (age_reg != 3'h7)
			age_reg <= age_reg + 3'h1;
	end
	wire ok = age_reg > 3'h4;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sep_read_a: assert property (ok && !$past(strobe_scheme_select, 3)
		|-> data_oe == $past(!chip_sel_n && !read_n, 3)) else $error("bad read");
	com_read_a: assert property (ok && $past(strobe_scheme_select, 3)
		|-> data_oe == $past(!chip_sel_n && read_n, 3)) else $error("bad read");
	cs_idle_a: assert property (chip_sel_n [*3] |=> !data_oe)
		else $error("bus driven");
	rst_clear_a: assert property ($rose(reset_n) |-> !data_oe && sample_oe == '0)
		else $error("not cleared");
	fmt_a: assert property (ok |-> sample_out ==
		($past(sample_in) ^ {4{$past(output_format_select, 3), 19'h0_0000}}))
		else $error("bad format");
	twos_a: assert property (ok && !$past(output_format_select, 3)
		|-> sample_out == $past(sample_in)) else $error("bad pass");
	norm_oe_a: assert property (ok && !$past(tester_group_tristate, 3) |->
		sample_oe == {{40{$past(output_drive_enable_code[1], 3)}},
		{40{$past(output_drive_enable_code[0], 3)}}}) else $error("bad enable");
	test_oe_a: assert property (ok && $past(tester_group_tristate, 3) |->
		sample_oe == {{40{$past(output_drive_enable_code[1], 3)}},
		{40{$past(output_drive_enable_code[0], 3)}}}) else $error("bad group");
	cover property (data_oe && strobe_scheme_select);
	cover property (data_oe && !strobe_scheme_select);
	cover property (tester_group_tristate && sample_oe != '0);
endmodule : hspo_top_asserts
bind hspo_top hspo_top_asserts i_chk (.*);

// [tb/hspo_host_model.sv]
`timescale 1ns/10ps
module hspo_host_model (
	input wire logic clk, // Clock.
	input wire logic mode, // High for common strobe.
	input wire logic [15:0] q, // Read data.
	input wire logic oe, // Read data driven.
	output logic cs_n, // Chip select.
	output logic rd_n, // Read strobe or select.
	output logic wr_n, // Write or data strobe.
	output logic [6:0] a, // Address.
	output logic [15:0] d // Write data.
);
	// The bus idles deselected with both strobes high.
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		a = 7'h00;
		d = 16'h0000;
	end
	// Strobe low three cycles then high three, all else held.
	task automatic wr(input logic [6:0] t, input logic [15:0] v, input logic c);
		@(negedge clk);
		cs_n = c;
		rd_n = !mode;
		a = t;
		d = v;
		wr_n = 1'b0;
		repeat (3) @(negedge clk);
		wr_n = 1'b1;
		repeat (3) @(negedge clk);
		cs_n = 1'b1;
		rd_n = 1'b1;
		d = ~v;
		repeat (3) @(negedge clk);
	endtask : wr
	// Holds the read until the bus is driven, for eight cycles at most.
	task automatic rd(input logic [6:0] t, output logic [15:0] v, output logic ok);
		@(negedge clk);
		cs_n = 1'b0;
		rd_n = mode;
		a = t;
		ok = 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(negedge clk);
			ok = oe === 1'b1;
		end
		v = q;
		cs_n = 1'b1;
		rd_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask : rd
endmodule : hspo_host_model

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	logic clk, reset_n, mode, fmt, tst, cs_n, rd_n, wr_n, oe;
	logic [1:0] code;
	logic [6:0] a;
	logic [15:0] d, q;
	logic [79:0] si, so, soe;
	int failures, samples_checked;
	hspo_top i_dut (.clk(clk), .reset_n(reset_n), .strobe_scheme_select(mode),
		.chip_sel_n(cs_n), .read_n(rd_n), .write_n(wr_n), .addr(a), .data_in(d),
		.data_out(q), .data_oe(oe), .output_format_select(fmt),
		.tester_group_tristate(tst), .output_drive_enable_code(code),
		.sample_in(si), .sample_out(so), .sample_oe(soe));
	hspo_host_model i_host (.clk(clk), .mode(mode), .q(q), .oe(oe), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .a(a), .d(d));
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	// Clock at 10 MHz.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Writes, refused writes and read-back, then output format and enables.
	initial begin
		logic [15:0] r, v;
		logic [6:0] t;
		logic ok;
		void'($urandom(32'h0000_22a5));
		{reset_n, mode, fmt, tst, code, si} = '0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		for (int n = 0; n < 6; n++) begin
			mode = n[0];
			t = (n < 2) ? 7'h00 : (n < 4) ? 7'h7f : 7'($urandom());
			v = 16'($urandom());
			i_host.wr(t, v, 1'b0);
			i_host.wr(t, ~v, 1'b1);
			i_host.rd(t, r, ok);
			chk(80'(ok), 80'h1);
			if (!ok)
				test_done();
			chk(80'(r), 80'(v));
		end
		for (int n = 0; n < 16; n++) begin
			{tst, fmt, code} = n[3:0];
			si = 80'({$urandom(), $urandom(), $urandom()});
			repeat (4) @(negedge clk);
			chk(so, si ^ {4{fmt, 19'h0_0000}});
			chk(soe, {{40{code[1]}}, {40{code[0]}}});
		end
		test_done();
	end
endmodule : tb_top
